// ==== rtl/aps_adc_ctrl.sv ====
// Converter power, sleep, idle and result format control with an AXI4-Lite register slave
`timescale 1ns/100ps

// Function
// - Power bit 1 keeps the converter active, powered and able to convert, unless a sleep-completion shutdown has turned it off.
// - Power bit 0 turns converter digital and analog sections off.
// - Processor sleep stops converter clocks, held low, unless the RC clock is selected.
// - Sleep during a conversion not RC-clocked aborts it; no resumption afterwards.
// - Sleep entry and exit leave all converter registers unchanged.
// - RC clock keeps running in sleep; start delayed one instruction cycle.
// - Finishing a conversion sets the conversion-complete flag.
// - Sleep conversion end wakes if enabled, else turns module off, power bit kept.
// - Idle keeps converter running when stop-in-idle is 0, halts it when 1.
// - Reset restores registers, turns module off, aborts sampling and converting.
// - Reset leaves the result buffer contents untouched.
// - Result buffer is undefined after power-on until a conversion writes it.
// - Results stored in 12 bits, read as 16-bit words in four formats.
// - Bus writes to the result buffer are always right-justified integers.
// - Fractional reads put bits 11..0 on 15..4, low four bits zero.
// - Integer reads use bits 11..0; top bits sign copy or zero.
module aps_adc_ctrl (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Processor power state, same clock domain
    input  wire logic        cpu_sleep,
    input  wire logic        cpu_idle,
    // Analog converter core
    input  wire logic [11:0] core_result,
    output logic             core_power_en,
    output logic             core_clk_en,
    output logic             core_sample,
    output logic             core_convert,
    output logic             wake_req
);
    localparam int AW_IDX = $clog2(aps_pkg::APS_RBUF_DEPTH);

    typedef struct packed {
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [1:0]        rresp;
        logic [31:0]       rdata;
        logic              converter_power_on;
        logic              rc_conversion_clock_select;
        logic              stop_in_idle_select;
        logic [1:0]        form;
        logic              int_en;
        logic              done;
        logic              sleep_off;
        logic              wake;
        logic [3:0]        tad_cnt;
        logic [3:0]        rc_cnt;
        logic [AW_IDX-1:0] wr_ptr;
        logic              core_pwr;
        logic              core_clk;
        logic              core_smp;
        logic              core_cnv;
    } aps_state_t;

    aps_state_t s_q;
    aps_state_t s_d;

    // Result storage: 12 bits per word, outside reset
    logic [11:0] result_buffer [aps_pkg::APS_RBUF_DEPTH];

    aps_seq_if sqi ();

    logic              active;
    logic              clk_stop;
    logic              tad_tick;
    logic              rc_tick;
    logic              wr_fire;
    logic              rd_fire;
    logic              start_req;
    logic              aw_is_ctrl;
    logic              aw_is_stat;
    logic              aw_is_rbuf;
    logic              ar_is_ctrl;
    logic              ar_is_stat;
    logic              ar_is_rbuf;
    logic [AW_IDX-1:0] aw_idx;
    logic [AW_IDX-1:0] ar_idx;
    logic [11:0]       rbuf_old;
    logic [11:0]       rbuf_wr_val;
    logic              rbuf_bus_we;
    logic [15:0]       rd_word;

    aps_seq u_seq (
        .aclk    (aclk),
        .aresetn (aresetn),
        .sq      (sqi.seq)
    );

    aps_fmt u_fmt (
        .raw  (result_buffer[ar_idx]),
        .form (s_q.form),
        .word (rd_word)
    );

    // Address decode; low two bits are ignored, every register is one aligned word
    always_comb begin
        aw_is_ctrl = (s_axi_awaddr[7:2] == aps_pkg::APS_CTRL_OFF[7:2]);
        aw_is_stat = (s_axi_awaddr[7:2] == aps_pkg::APS_STAT_OFF[7:2]);
        aw_is_rbuf = (s_axi_awaddr[7:6] == aps_pkg::APS_RBUF_BASE[7:6]);
        ar_is_ctrl = (s_axi_araddr[7:2] == aps_pkg::APS_CTRL_OFF[7:2]);
        ar_is_stat = (s_axi_araddr[7:2] == aps_pkg::APS_STAT_OFF[7:2]);
        ar_is_rbuf = (s_axi_araddr[7:6] == aps_pkg::APS_RBUF_BASE[7:6]);
        aw_idx     = s_axi_awaddr[AW_IDX+1:2];
        ar_idx     = s_axi_araddr[AW_IDX+1:2];
    end

    // Handshakes complete in the cycle our registered ready is high
    assign wr_fire = s_q.awready & s_q.wready & s_axi_awvalid & s_axi_wvalid;
    assign rd_fire = s_q.arready & s_axi_arvalid;

    // Module state: powered unless the sleep-completion shutdown has taken it off
    assign active = s_q.converter_power_on & ~s_q.sleep_off;

    // Conversion clocks stop in sleep unless RC-clocked, and in idle when asked to
    assign clk_stop = (cpu_sleep & ~s_q.rc_conversion_clock_select)
                    | (cpu_idle & s_q.stop_in_idle_select);
    assign tad_tick = (s_q.tad_cnt == aps_pkg::APS_TAD_DIV_CYC - 4'h1);
    assign rc_tick  = (s_q.rc_cnt == aps_pkg::APS_RC_DIV_CYC - 4'h1);

    // A start request is only honoured on an active, idle converter
    assign start_req = wr_fire & aw_is_ctrl & s_axi_wstrb[1]
                     & s_axi_wdata[aps_pkg::APS_CTRL_START_BIT] & active & ~sqi.busy;

    // Sequencer steering
    assign sqi.rc_sel = s_q.rc_conversion_clock_select;
    assign sqi.start  = start_req;
    assign sqi.tick   = active & ~clk_stop
                      & (s_q.rc_conversion_clock_select ? rc_tick : tad_tick);
    assign sqi.abort  = ~active | (cpu_sleep & ~s_q.rc_conversion_clock_select);

    // Bus writes to the buffer are taken as right-justified integers, byte lanes merged
    assign rbuf_old    = result_buffer[aw_idx];
    assign rbuf_wr_val = {s_axi_wstrb[1] ? s_axi_wdata[11:8] : rbuf_old[11:8],
                          s_axi_wstrb[0] ? s_axi_wdata[7:0]  : rbuf_old[7:0]};
    assign rbuf_bus_we = wr_fire & aw_is_rbuf & ~sqi.done_pulse;

    // Buffer write port: a finished conversion has priority over a bus write
    always_ff @(posedge aclk) begin
        if (sqi.done_pulse) begin
            result_buffer[s_q.wr_ptr] <= core_result;
        end else if (rbuf_bus_we) begin
            result_buffer[aw_idx] <= rbuf_wr_val;
        end
    end

    // Next-state logic for the bus slave, control fields and converter outputs
    always_comb begin
        s_d      = s_q;
        s_d.wake = 1'b0;

        // Write channel: take address and data together, answer once both are in
        if (wr_fire) begin
            s_d.awready = 1'b0;
            s_d.wready  = 1'b0;
            s_d.bvalid  = 1'b1;
            s_d.bresp   = (aw_is_ctrl | aw_is_stat | aw_is_rbuf) ? aps_pkg::APS_RESP_OKAY
                                                                 : aps_pkg::APS_RESP_SLVERR;
        end else if (s_axi_awvalid & s_axi_wvalid & ~s_q.awready & ~s_q.bvalid) begin
            s_d.awready = 1'b1;
            s_d.wready  = 1'b1;
        end
        if (s_q.bvalid & s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end

        // Read channel: data is latched at the address handshake and then held
        if (rd_fire) begin
            s_d.arready = 1'b0;
            s_d.rvalid  = 1'b1;
            s_d.rresp   = aps_pkg::APS_RESP_OKAY;
            s_d.rdata   = aps_pkg::APS_RDATA_RST;
            if (ar_is_ctrl) begin
                s_d.rdata[aps_pkg::APS_CTRL_PWR_BIT]  = s_q.converter_power_on;
                s_d.rdata[aps_pkg::APS_CTRL_RC_BIT]   = s_q.rc_conversion_clock_select;
                s_d.rdata[aps_pkg::APS_CTRL_SIDL_BIT] = s_q.stop_in_idle_select;
                s_d.rdata[aps_pkg::APS_CTRL_FORM_LSB +: 2] = s_q.form;
                s_d.rdata[aps_pkg::APS_CTRL_IE_BIT]   = s_q.int_en;
            end else if (ar_is_stat) begin
                s_d.rdata[aps_pkg::APS_STAT_DONE_BIT] = s_q.done;
                s_d.rdata[aps_pkg::APS_STAT_BUSY_BIT] = sqi.busy;
                s_d.rdata[aps_pkg::APS_STAT_ACT_BIT]  = active;
                s_d.rdata[aps_pkg::APS_STAT_SOFF_BIT] = s_q.sleep_off;
                s_d.rdata[aps_pkg::APS_STAT_SAMP_BIT] = sqi.sampling;
            end else if (ar_is_rbuf) begin
                s_d.rdata[15:0] = rd_word;
            end else begin
                s_d.rresp = aps_pkg::APS_RESP_SLVERR;
            end
        end else if (s_axi_arvalid & ~s_q.arready & ~s_q.rvalid) begin
            s_d.arready = 1'b1;
        end
        if (s_q.rvalid & s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end

        // Control writes; sleep and idle never touch these fields
        if (wr_fire & aw_is_ctrl & s_axi_wstrb[0]) begin
            s_d.converter_power_on         = s_axi_wdata[aps_pkg::APS_CTRL_PWR_BIT];
            s_d.rc_conversion_clock_select = s_axi_wdata[aps_pkg::APS_CTRL_RC_BIT];
            s_d.stop_in_idle_select        = s_axi_wdata[aps_pkg::APS_CTRL_SIDL_BIT];
            s_d.form                       = s_axi_wdata[aps_pkg::APS_CTRL_FORM_LSB +: 2];
            s_d.int_en                     = s_axi_wdata[aps_pkg::APS_CTRL_IE_BIT];
        end

        // A control write or a cleared power bit revives the module after a sleep shutdown
        if ((wr_fire & aw_is_ctrl) | ~s_q.converter_power_on) begin
            s_d.sleep_off = 1'b0;
        end

        // Done flag: write one to clear
        if (wr_fire & aw_is_stat & s_axi_wstrb[0] & s_axi_wdata[aps_pkg::APS_STAT_DONE_BIT]) begin
            s_d.done = 1'b0;
        end

        // Completion comes after the clears so a same-cycle event is never lost
        if (sqi.done_pulse) begin
            s_d.done   = 1'b1;
            s_d.wr_ptr = s_q.wr_ptr + 1'b1;
            if (cpu_sleep) begin
                if (s_q.int_en) begin
                    s_d.wake = 1'b1;
                end else begin
                    s_d.sleep_off = 1'b1;
                end
            end
        end

        // Conversion clock dividers clear to zero while their clock is stopped or not selected
        if (active & ~clk_stop & ~s_q.rc_conversion_clock_select) begin
            s_d.tad_cnt = tad_tick ? aps_pkg::APS_CNT4_RST : s_q.tad_cnt + 4'h1;
        end else begin
            s_d.tad_cnt = aps_pkg::APS_CNT4_RST;
        end
        if (active & ~clk_stop & s_q.rc_conversion_clock_select) begin
            s_d.rc_cnt = rc_tick ? aps_pkg::APS_CNT4_RST : s_q.rc_cnt + 4'h1;
        end else begin
            s_d.rc_cnt = aps_pkg::APS_CNT4_RST;
        end

        // Analog side: power follows the active state, clock gate held low when stopped
        s_d.core_pwr = active;
        s_d.core_clk = active & ~clk_stop;
        s_d.core_smp = sqi.sampling & ~sqi.abort;
        s_d.core_cnv = sqi.busy & ~sqi.sampling & ~sqi.abort;
    end

    // One register for all state; the result buffer is kept out of reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q.awready                    <= 1'b0;
            s_q.wready                     <= 1'b0;
            s_q.bvalid                     <= 1'b0;
            s_q.bresp                      <= aps_pkg::APS_RESP_OKAY;
            s_q.arready                    <= 1'b0;
            s_q.rvalid                     <= 1'b0;
            s_q.rresp                      <= aps_pkg::APS_RESP_OKAY;
            s_q.rdata                      <= aps_pkg::APS_RDATA_RST;
            s_q.converter_power_on         <= 1'b0;
            s_q.rc_conversion_clock_select <= 1'b0;
            s_q.stop_in_idle_select        <= 1'b0;
            s_q.form                       <= aps_pkg::APS_FORM_RST;
            s_q.int_en                     <= 1'b0;
            s_q.done                       <= 1'b0;
            s_q.sleep_off                  <= 1'b0;
            s_q.wake                       <= 1'b0;
            s_q.tad_cnt                    <= aps_pkg::APS_CNT4_RST;
            s_q.rc_cnt                     <= aps_pkg::APS_CNT4_RST;
            s_q.wr_ptr                     <= '0;
            s_q.core_pwr                   <= 1'b0;
            s_q.core_clk                   <= 1'b0;
            s_q.core_smp                   <= 1'b0;
            s_q.core_cnv                   <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign s_axi_awready = s_q.awready;
    assign s_axi_wready  = s_q.wready;
    assign s_axi_bvalid  = s_q.bvalid;
    assign s_axi_bresp   = s_q.bresp;
    assign s_axi_arready = s_q.arready;
    assign s_axi_rvalid  = s_q.rvalid;
    assign s_axi_rresp   = s_q.rresp;
    assign s_axi_rdata   = s_q.rdata;
    assign core_power_en = s_q.core_pwr;
    assign core_clk_en   = s_q.core_clk;
    assign core_sample   = s_q.core_smp;
    assign core_convert  = s_q.core_cnv;
    assign wake_req      = s_q.wake;
endmodule

// ==== rtl/aps_pkg.sv ====
// Package of offsets, field positions, reset values and timing for the converter control block
package aps_pkg;

    // Register map, byte addresses on the 8-bit AXI4-Lite address
    localparam logic [7:0]  APS_CTRL_OFF      = 8'h00;
    localparam logic [7:0]  APS_STAT_OFF      = 8'h04;
    localparam logic [7:0]  APS_RBUF_BASE     = 8'h40;
    localparam int          APS_RBUF_DEPTH    = 16;

    // Control register fields
    localparam int          APS_CTRL_PWR_BIT   = 0;
    localparam int          APS_CTRL_RC_BIT    = 1;
    localparam int          APS_CTRL_SIDL_BIT  = 2;
    localparam int          APS_CTRL_FORM_LSB  = 4;
    localparam int          APS_CTRL_IE_BIT    = 6;
    localparam int          APS_CTRL_START_BIT = 8;

    // Status register fields
    localparam int          APS_STAT_DONE_BIT  = 0;
    localparam int          APS_STAT_BUSY_BIT  = 1;
    localparam int          APS_STAT_ACT_BIT   = 2;
    localparam int          APS_STAT_SOFF_BIT  = 3;
    localparam int          APS_STAT_SAMP_BIT  = 4;

    // Values after reset
    localparam logic [1:0]  APS_FORM_RST      = 2'h0;
    localparam logic [3:0]  APS_CNT4_RST      = 4'h0;
    localparam logic [31:0] APS_RDATA_RST     = 32'h0000_0000;

    // AXI responses
    localparam logic [1:0]  APS_RESP_OKAY     = 2'h0;
    localparam logic [1:0]  APS_RESP_SLVERR   = 2'h2;

    // Read formats of the result buffer
    typedef enum logic [1:0] {
        APS_FORM_UINT  = 2'b00,
        APS_FORM_SINT  = 2'b01,
        APS_FORM_FRAC  = 2'b10,
        APS_FORM_SFRAC = 2'b11
    } aps_form_t;

    // Timing: instruction cycle delay before an RC-clocked start
    localparam int          APS_CLK_PERIOD_NS = 100;
    localparam int          APS_INSTR_NS      = 100;
    localparam logic [4:0]  APS_START_DLY_CYC = 5'((APS_INSTR_NS + APS_CLK_PERIOD_NS - 1) / APS_CLK_PERIOD_NS);

    // Conversion clock dividers in system clocks, sequence lengths counted in conversion ticks
    localparam logic [3:0]  APS_TAD_DIV_CYC   = 4'h4;
    localparam logic [3:0]  APS_RC_DIV_CYC    = 4'h6;
    localparam logic [4:0]  APS_SAMP_TICKS    = 5'h03;
    localparam logic [4:0]  APS_CONV_TICKS    = 5'h0e;

endpackage

// ==== rtl/aps_seq_if.sv ====
// Interface between the control block and its sample/convert sequencer
`timescale 1ns/100ps
interface aps_seq_if;
    logic tick;
    logic start;
    logic abort;
    logic rc_sel;
    logic busy;
    logic sampling;
    logic done_pulse;

    modport seq (input tick, input start, input abort, input rc_sel,
                 output busy, output sampling, output done_pulse);
    modport ctl (output tick, output start, output abort, output rc_sel,
                 input busy, input sampling, input done_pulse);
endinterface

// ==== rtl/aps_fmt.sv ====
// Result word formatter: 12-bit stored value to 16-bit bus word
`timescale 1ns/100ps
module aps_fmt (
    input  wire logic [11:0] raw,
    input  wire logic [1:0]  form,
    output logic      [15:0] word
);
    // Fractional forms left-justify, integer forms right-justify
    always_comb begin
        case (aps_pkg::aps_form_t'(form))
            aps_pkg::APS_FORM_UINT:  word = {4'h0, raw};
            aps_pkg::APS_FORM_SINT:  word = {{4{raw[11]}}, raw};
            aps_pkg::APS_FORM_FRAC:  word = {raw, 4'h0};
            aps_pkg::APS_FORM_SFRAC: word = {raw, 4'h0};
            default:                 word = {4'h0, raw};
        endcase
    end
endmodule

// ==== rtl/aps_seq.sv ====
// Sample and convert sequencer, stepped by conversion clock ticks except the RC start delay, counted in system clocks
`timescale 1ns/100ps
module aps_seq (
    input  wire logic aclk,
    input  wire logic aresetn,
    aps_seq_if.seq    sq
);
    typedef enum logic [1:0] {
        APS_SQ_IDLE  = 2'b00,
        APS_SQ_DELAY = 2'b01,
        APS_SQ_SAMP  = 2'b10,
        APS_SQ_CONV  = 2'b11
    } aps_sq_state_t;

    typedef struct packed {
        aps_sq_state_t st;
        logic [4:0]    cnt;
        logic          done;
    } aps_sq_t;

    aps_sq_t s_q;
    aps_sq_t s_d;

    // Abort beats everything; partial conversions are never resumed
    always_comb begin
        s_d      = s_q;
        s_d.done = 1'b0;
        if (sq.abort) begin
            s_d.st  = APS_SQ_IDLE;
            s_d.cnt = 5'h00;
        end else begin
            case (s_q.st)
                APS_SQ_IDLE: begin
                    if (sq.start) begin
                        s_d.cnt = 5'h00;
                        s_d.st  = sq.rc_sel ? APS_SQ_DELAY : APS_SQ_SAMP;
                    end
                end
                // Counted in system clocks so the sleep entry lands before sampling
                APS_SQ_DELAY: begin
                    if (s_q.cnt == aps_pkg::APS_START_DLY_CYC - 5'h01) begin
                        s_d.cnt = 5'h00;
                        s_d.st  = APS_SQ_SAMP;
                    end else begin
                        s_d.cnt = s_q.cnt + 5'h01;
                    end
                end
                APS_SQ_SAMP: begin
                    if (sq.tick) begin
                        if (s_q.cnt == aps_pkg::APS_SAMP_TICKS - 5'h01) begin
                            s_d.cnt = 5'h00;
                            s_d.st  = APS_SQ_CONV;
                        end else begin
                            s_d.cnt = s_q.cnt + 5'h01;
                        end
                    end
                end
                APS_SQ_CONV: begin
                    if (sq.tick) begin
                        if (s_q.cnt == aps_pkg::APS_CONV_TICKS - 5'h01) begin
                            s_d.cnt  = 5'h00;
                            s_d.st   = APS_SQ_IDLE;
                            s_d.done = 1'b1;
                        end else begin
                            s_d.cnt = s_q.cnt + 5'h01;
                        end
                    end
                end
                default: begin
                    s_d.st  = APS_SQ_IDLE;
                    s_d.cnt = 5'h00;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '{st: APS_SQ_IDLE, cnt: 5'h00, done: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign sq.busy       = (s_q.st != APS_SQ_IDLE);
    assign sq.sampling   = (s_q.st == APS_SQ_SAMP);
    assign sq.done_pulse = s_q.done;
endmodule

// ==== sim/aps_core_model.sv ====
// Model of the analog converter core
`timescale 1ns/100ps
module aps_core_model (
    input  wire logic        aclk,
    input  wire logic        core_power_en,
    input  wire logic        core_convert,
    input  wire logic [11:0] level,
    output logic      [11:0] core_result
);
    initial core_result = 12'h000;
    // Idle core toggles its output so stale data fails
    always @(posedge aclk) begin
        core_result <= (core_power_en && core_convert) ? level : ~core_result;
    end
endmodule

// ==== sim/aps_adc_ctrl_asserts.sv ====
// Port assertions for the converter control block
`timescale 1ns/100ps
module aps_adc_ctrl_asserts (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        cpu_sleep,
    input wire logic        cpu_idle,
    input wire logic        s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        core_power_en,
    input wire logic        core_clk_en,
    input wire logic        core_sample,
    input wire logic        core_convert,
    input wire logic        wake_req
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Sampling ends, power and clock on
    sequence s_samp_end;
        core_sample ##1 (!core_sample && core_power_en && core_clk_en);
    endsequence
    a_rst_quiet: assert property (disable iff (1'b0) !aresetn |=> !core_power_en && !core_convert)
        else $error("core active after reset");
    a_off_quiet: assert property (!core_power_en |-> !core_sample && !core_convert)
        else $error("core busy while off");
    a_clk_power: assert property (core_clk_en |-> core_power_en)
        else $error("clock without power");
    a_samp_conv: assert property (s_samp_end |-> core_convert)
        else $error("no conversion after sampling");
    a_sleep_abort: assert property (cpu_sleep && !cpu_idle && !core_clk_en |-> ##[0:2] !core_sample && !core_convert)
        else $error("conversion kept in sleep");
    a_wake_sleep: assert property (wake_req |-> $past(cpu_sleep) || $past(cpu_sleep, 2))
        else $error("wake outside sleep");
    a_wake_pulse: assert property (wake_req |=> !wake_req)
        else $error("wake longer than a pulse");
    a_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("upper read bits set");
endmodule

bind aps_adc_ctrl aps_adc_ctrl_asserts aps_adc_ctrl_asserts_inst (.aclk, .aresetn, .cpu_sleep, .cpu_idle,
    .s_axi_rvalid, .s_axi_rdata, .core_power_en, .core_clk_en, .core_sample, .core_convert, .wake_req);

// ==== sim/aps_adc_ctrl_test.sv ====
// Self-checking bench for the converter control block
`timescale 1ns/100ps
module aps_adc_ctrl_test;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cpu_sleep, cpu_idle;
    logic        core_power_en, core_clk_en, core_sample, core_convert, wake_req, woke;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic [11:0] core_result;
    int          err_count = 0;
    int          n_tests = 0;
    localparam logic [11:0] LVL = 12'h9c3;
    localparam logic [7:0]  CT = aps_pkg::APS_CTRL_OFF;
    localparam logic [7:0]  ST = aps_pkg::APS_STAT_OFF;
    localparam logic [7:0]  RB = aps_pkg::APS_RBUF_BASE;
    localparam logic [15:0] FMT [4] = '{16'h08a5, 16'hf8a5, 16'h8a50, 16'h8a50};
    aps_adc_ctrl aps_adc_ctrl_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpu_sleep,
        .cpu_idle, .core_result, .core_power_en, .core_clk_en, .core_sample, .core_convert, .wake_req);
    aps_core_model aps_core_model_inst (.aclk, .core_power_en, .core_convert, .level(LVL), .core_result);
    task automatic chk(input logic [31:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Valids hold until taken; answer ready rises with them
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (!s_axi_awready);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, {30'h0, er});
        @(posedge aclk);
    endtask
    task automatic rdr(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        @(posedge aclk);
    endtask
    // Bounded poll of the done flag
    task automatic wait_done;
        for (int i = 0; i < 80; i++) begin
            rdr(ST);
            if (rd[0] === 1'b1) break;
        end
    endtask
    task automatic end_sim;
        if (err_count == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic t_convert;
        rdr(CT);
        chk(rd, 32'h0);
        chk({31'h0, core_power_en}, 32'h0);
        wr(CT, 32'h1);
        repeat (20) @(posedge aclk); // Settle time
        chk({31'h0, core_power_en}, 32'h1);
        wr(CT, 32'h101);
        wait_done;
        chk({31'h0, rd[0]}, 32'h1);
        rdr(RB);
        chk(rd, {20'h0, LVL});
    endtask
    task automatic t_sleep;
        wr(ST, 32'h1);
        wr(CT, 32'h43);
        wr(CT, 32'h143);
        woke <= 1'b0;
        cpu_sleep <= 1'b1;
        repeat (4) @(posedge aclk);
        chk({31'h0, core_clk_en}, 32'h1);
        for (int i = 0; i < 200 && !woke; i++) @(posedge aclk);
        chk({31'h0, woke}, 32'h1);
        cpu_sleep <= 1'b0;
        wait_done;
        rdr(RB + 8'h04);
        chk(rd, {20'h0, LVL});
        wr(CT, 32'h103);
        cpu_sleep <= 1'b1;
        repeat (150) @(posedge aclk);
        rdr(CT);
        chk({rd[30:0], core_power_en}, 32'h6);
        cpu_sleep <= 1'b0;
        wr(ST, 32'h1);
        wr(CT, 32'h1);
        wr(CT, 32'h101);
        repeat (20) @(posedge aclk);
        cpu_sleep <= 1'b1;
        repeat (3) @(posedge aclk);
        chk({30'h0, core_clk_en, core_convert}, 32'h0);
        cpu_sleep <= 1'b0;
        repeat (120) @(posedge aclk);
        rdr(ST);
        chk({31'h0, rd[0]}, 32'h0);
        rdr(CT);
        chk(rd, 32'h1);
    endtask
    task automatic t_misc;
        wr(CT, 32'h5);
        cpu_idle <= 1'b1;
        repeat (3) @(posedge aclk);
        chk({31'h0, core_clk_en}, 32'h0);
        wr(CT, 32'h1);
        repeat (3) @(posedge aclk);
        chk({31'h0, core_clk_en}, 32'h1);
        cpu_idle <= 1'b0;
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rdr(CT);
        chk(rd, 32'h0);
        rdr(RB);
        chk(rd, {20'h0, LVL});
        wr(RB + 8'h08, 32'h0000_f8a5);
        for (int f = 0; f < 4; f++) begin
            wr(CT, {26'h0, f[1:0], 4'h0});
            rdr(RB + 8'h08);
            chk(rd, {16'h0, FMT[f]});
        end
        wr(8'h20, 32'h1, aps_pkg::APS_RESP_SLVERR);
        rdr(8'h20);
        chk({rd[29:0], rs}, {30'h0, aps_pkg::APS_RESP_SLVERR});
    endtask
    // Clock and a latch for the wake pulse
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    always @(posedge aclk) if (wake_req === 1'b1) woke <= 1'b1;
    // Run limit of 20000 cycles
    initial begin
        #2_000_000;
        err_count++;
        end_sim;
    end
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {cpu_sleep, cpu_idle, woke, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_convert;
        t_sleep;
        t_misc;
        end_sim;
    end
endmodule
